// ### inc/prs_pkg.sv
// Package for the point table repeat sequencer.
// Assumes one 50 MHz clock domain; no software registers.
package prs_pkg;
   localparam int PRS_CLK_HZ = 50000000;
   localparam int PRS_ENTRY_W = 8;
   localparam int PRS_POS_W = 32;
   localparam int PRS_SPD_W = 16;
   localparam int PRS_TC_W = 16;
   localparam int PRS_DWELL_W = 16;
   localparam int PRS_SUB_W = 4;
   // Sub-function codes
   localparam logic [3:0] PRS_SUB_ABS_END = 4'h0;
   localparam logic [3:0] PRS_SUB_ABS_CONT = 4'h1;
   localparam logic [3:0] PRS_SUB_INC_END = 4'h2;
   localparam logic [3:0] PRS_SUB_INC_CONT = 4'h3;
   localparam logic [3:0] PRS_SUB_RPT_START = 4'h8;
   localparam logic [3:0] PRS_SUB_RPT_FIRST = 4'h9;
   localparam logic [3:0] PRS_SUB_RPT_START_INC = 4'ha;
   localparam logic [3:0] PRS_SUB_RPT_FIRST_INC = 4'hb;
   // Reset values and fixed entries
   localparam logic [7:0] PRS_FIRST_ENTRY = 8'h01;
   localparam logic [7:0] PRS_ENTRY_RST = 8'h00;
   // Command method: absolute = 0, incremental = 1
   localparam logic PRS_METHOD_ABS = 1'b0;
   localparam logic PRS_METHOD_INC = 1'b1;
   typedef enum logic [1:0] {
      PRS_NEXT_STOP,
      PRS_NEXT_SEQ,
      PRS_NEXT_START,
      PRS_NEXT_FIRST
   } prs_next_e;
endpackage

// ### src/prs_sub_decode.sv
// Decoder of an entry's sub-function code into move type and follow-on action.
// Assumes the code is stable while looked at; purely combinational.
`timescale 1ns/10ps
`default_nettype none
module prs_sub_decode
   import prs_pkg::*;
(
   input wire logic [3:0] sub_code,
   output logic move_incremental,
   output prs_next_e next_action
);
   always_comb
   begin
      move_incremental = 1'b0;
      next_action = PRS_NEXT_STOP;
      case (sub_code)
         PRS_SUB_ABS_END:
         begin
            next_action = PRS_NEXT_STOP;
         end
         PRS_SUB_ABS_CONT:
         begin
            next_action = PRS_NEXT_SEQ;
         end
         PRS_SUB_INC_END:
         begin
            move_incremental = 1'b1;
         end
         PRS_SUB_INC_CONT:
         begin
            move_incremental = 1'b1;
            next_action = PRS_NEXT_SEQ;
         end
         PRS_SUB_RPT_START:
         begin
            next_action = PRS_NEXT_START; // R11
         end
         PRS_SUB_RPT_FIRST:
         begin
            next_action = PRS_NEXT_FIRST; // R11
         end
         PRS_SUB_RPT_START_INC:
         begin
            move_incremental = 1'b1; // R4
            next_action = PRS_NEXT_START; // R11
         end
         PRS_SUB_RPT_FIRST_INC:
         begin
            move_incremental = 1'b1; // R7
            next_action = PRS_NEXT_FIRST; // R11
         end
         default:
         begin
            next_action = PRS_NEXT_STOP;
         end
      endcase
   end
endmodule // prs_sub_decode
`default_nettype wire

// ### src/prs_sequencer.sv
// Point table repeat sequencer: walks chained point table entries.
// Assumes a point table memory answering entry_data_* one cycle after entry_rd,
// and a profile generator that pulses move_done when positioning completes.
//
// Overview of operation
// R1 - Codes 9 or 11 finishing restart the chain at entry 1.
// R2 - Consecutive entries run up to and including the repeat entry.
// R3 - Absolute method code 8 resumes at the start-up entry.
// R4 - Code 10 moves incrementally then resumes at the start-up entry.
// R5 - Start-up entry number is held throughout operation.
// R6 - Code 9 jumps to entry 1 even if started later.
// R7 - Code 11 moves incrementally then jumps to entry 1.
// R8 - Repeat loop continues until operation is stopped externally.
// R9 - Absolute method codes 8 and 10 return to start-up entry.
// R10 - Host ends non-repeating chains with code 0 or 2.
// R11 - Codes 8 to 11 decode into repeat target and move type.
`timescale 1ns/10ps
`default_nettype none
module prs_sequencer
   import prs_pkg::*;
#(
   parameter int ENTRY_W = PRS_ENTRY_W,
   parameter int POS_W = PRS_POS_W,
   parameter int SPD_W = PRS_SPD_W,
   parameter int TC_W = PRS_TC_W,
   parameter int DWELL_W = PRS_DWELL_W
)
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic start_req,
   input wire logic stop_req,
   input wire logic [ENTRY_W-1:0] start_entry,
   input wire logic command_method_select,
   output logic entry_rd,
   output logic [ENTRY_W-1:0] entry_addr,
   input wire logic [POS_W-1:0] entry_data_pos,
   input wire logic [SPD_W-1:0] entry_data_speed,
   input wire logic [TC_W-1:0] entry_data_accel,
   input wire logic [TC_W-1:0] entry_data_decel,
   input wire logic [DWELL_W-1:0] entry_data_dwell,
   input wire logic [3:0] entry_data_sub,
   output logic move_start,
   output logic [POS_W-1:0] move_pos,
   output logic [SPD_W-1:0] move_speed,
   output logic [TC_W-1:0] move_accel,
   output logic [TC_W-1:0] move_decel,
   output logic [DWELL_W-1:0] move_dwell,
   output logic move_incremental,
   input wire logic move_done,
   output logic busy,
   output logic [ENTRY_W-1:0] current_entry
);
   // ************************************************************
   // State and decode
   // ************************************************************
   typedef enum logic [1:0] {
      PRS_IDLE,
      PRS_FETCH,
      PRS_LOAD,
      PRS_MOVE
   } prs_state_e;

   prs_state_e state_reg, state_next;
   logic [ENTRY_W-1:0] start_entry_reg, start_entry_next;
   logic [ENTRY_W-1:0] entry_reg, entry_next;
   logic [3:0] sub_reg, sub_next;
   logic [POS_W-1:0] pos_reg, pos_next;
   logic [SPD_W-1:0] speed_reg, speed_next;
   logic [TC_W-1:0] accel_reg, accel_next;
   logic [TC_W-1:0] decel_reg, decel_next;
   logic [DWELL_W-1:0] dwell_reg, dwell_next;
   logic inc_reg, inc_next;
   logic start_pulse_reg, start_pulse_next;
   logic dec_inc;
   logic [3:0] dec_sub;
   prs_next_e dec_next;
   localparam logic [ENTRY_W-1:0] FIRST = ENTRY_W'(PRS_FIRST_ENTRY);
   localparam logic [ENTRY_W-1:0] ERST = ENTRY_W'(PRS_ENTRY_RST);

   // Decoder sees the fresh code while loading, the held code afterwards
   assign dec_sub = (state_reg == PRS_LOAD) ? entry_data_sub : sub_reg;

   prs_sub_decode u_dec
   (
      .sub_code(dec_sub),
      .move_incremental(dec_inc),
      .next_action(dec_next)
   );

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb
   begin
      state_next = state_reg;
      start_entry_next = start_entry_reg;
      entry_next = entry_reg;
      sub_next = sub_reg;
      pos_next = pos_reg;
      speed_next = speed_reg;
      accel_next = accel_reg;
      decel_next = decel_reg;
      dwell_next = dwell_reg;
      inc_next = inc_reg;
      start_pulse_next = 1'b0;
      case (state_reg)
         PRS_IDLE:
         begin
            if (start_req)
            begin
               start_entry_next = start_entry; // R5
               entry_next = start_entry;
               state_next = PRS_FETCH;
            end
         end
         PRS_FETCH:
         begin
            state_next = PRS_LOAD;
         end
         PRS_LOAD:
         begin
            sub_next = entry_data_sub;
            pos_next = entry_data_pos;
            speed_next = entry_data_speed;
            accel_next = entry_data_accel;
            decel_next = entry_data_decel;
            dwell_next = entry_data_dwell;
            // Codes 10/11 force incremental; others follow method or own code
            inc_next = dec_inc | (command_method_select == PRS_METHOD_INC); // R4 R7 R11
            start_pulse_next = 1'b1;
            state_next = PRS_MOVE;
         end
         PRS_MOVE:
         begin
            if (move_done)
            begin
               state_next = PRS_FETCH;
               case (dec_next)
                  PRS_NEXT_SEQ:
                  begin
                     entry_next = entry_reg + ENTRY_W'(1); // R2
                  end
                  PRS_NEXT_START:
                  begin
                     entry_next = start_entry_reg; // R3 R4 R5 R9 R8
                  end
                  PRS_NEXT_FIRST:
                  begin
                     entry_next = FIRST; // R1 R6 R7 R8
                  end
                  default:
                  begin
                     state_next = PRS_IDLE;
                  end
               endcase
            end
         end
         default:
         begin
            state_next = PRS_IDLE;
         end
      endcase
      // External stop is the only exit from a repeat loop
      if (stop_req)
      begin
         state_next = PRS_IDLE; // R8
         start_pulse_next = 1'b0;
      end
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         state_reg <= PRS_IDLE;
         start_entry_reg <= ERST;
         entry_reg <= ERST;
         sub_reg <= PRS_SUB_ABS_END;
         pos_reg <= '0;
         speed_reg <= '0;
         accel_reg <= '0;
         decel_reg <= '0;
         dwell_reg <= '0;
         inc_reg <= 1'b0;
         start_pulse_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         start_entry_reg <= start_entry_next;
         entry_reg <= entry_next;
         sub_reg <= sub_next;
         pos_reg <= pos_next;
         speed_reg <= speed_next;
         accel_reg <= accel_next;
         decel_reg <= decel_next;
         dwell_reg <= dwell_next;
         inc_reg <= inc_next;
         start_pulse_reg <= start_pulse_next;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign entry_rd = (state_reg == PRS_FETCH);
   assign entry_addr = entry_reg;
   assign move_start = start_pulse_reg;
   assign move_pos = pos_reg;
   assign move_speed = speed_reg;
   assign move_accel = accel_reg;
   assign move_decel = decel_reg;
   assign move_dwell = dwell_reg;
   assign move_incremental = inc_reg;
   assign busy = (state_reg != PRS_IDLE);
   assign current_entry = entry_reg;
endmodule // prs_sequencer
`default_nettype wire

// ### dv/prs_seq_checker.sv
// Checker of fetch timing, loop targets and move type.
// Assumes binding into prs_sequencer; one clock, async high reset.
`timescale 1ns/10ps
`default_nettype none
module prs_seq_checker
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic start_req,
   input wire logic stop_req,
   input wire logic [7:0] start_entry,
   input wire logic command_method_select,
   input wire logic entry_rd,
   input wire logic [7:0] entry_addr,
   input wire logic [3:0] entry_data_sub,
   input wire logic move_start,
   input wire logic move_incremental,
   input wire logic move_done,
   input wire logic busy
);
   logic [7:0] st_reg;
   logic fin;
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   assign fin = busy && move_done && !stop_req;
   // Start-up entry as taken
   always_ff @(posedge ref_clk or posedge reset)
      if (reset)
         st_reg <= 8'h00;
      else if (start_req && !busy && !stop_req)
         st_reg <= start_entry;
   start_fetch_a: assert property (start_req && !busy && !stop_req |=>
      entry_rd && entry_addr == $past(start_entry)) else $error("start fetch");
   fetch_load_a: assert property (entry_rd && !stop_req ##1 !stop_req |=> move_start)
      else $error("no move start");
   chain_step_a: assert property (fin && entry_data_sub inside {4'h1, 4'h3} |=>
      entry_rd && entry_addr == $past(entry_addr) + 8'h01) else $error("chain step");
   back_start_a: assert property (fin && entry_data_sub inside {4'h8, 4'ha} |=>
      entry_rd && entry_addr == st_reg) else $error("loop to start");
   back_first_a: assert property (fin && entry_data_sub inside {4'h9, 4'hb} |=>
      entry_rd && entry_addr == 8'h01) else $error("loop to first");
   chain_end_a: assert property (fin && entry_data_sub inside {4'h0, 4'h2} |=> !busy)
      else $error("chain end");
   move_type_a: assert property (move_start |-> move_incremental ==
      (command_method_select || entry_data_sub inside {4'h2, 4'h3, 4'ha, 4'hb}))
      else $error("move type");
   stop_idle_a: assert property (stop_req |=> !busy && !entry_rd) else $error("stop");
endmodule // prs_seq_checker
bind prs_sequencer prs_seq_checker chk (.*);
`default_nettype wire

// ### dv/prs_table_model.sv
// Far side: point table memory and profile generator done pulse.
// Assumes the sequencer's clock; done comes gap+1 cycles after move_start.
`timescale 1ns/10ps
`default_nettype none
module prs_table_model
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [7:0] entry_addr,
   input wire logic move_start,
   input wire logic [7:0] gap,
   output logic [31:0] pos,
   output logic [3:0] sub,
   output logic move_done
);
   logic [3:0] sub_mem [0:7];
   logic [7:0] cnt_reg;
   // Data held on entry_addr until done
   assign pos = {8'ha5, 16'h0000, entry_addr};
   assign sub = sub_mem[entry_addr[2:0]];
   always_ff @(posedge ref_clk or posedge reset)
      if (reset)
      begin
         cnt_reg <= 8'h00;
         move_done <= 1'b0;
      end
      else
      begin
         move_done <= cnt_reg == 8'h01;
         cnt_reg <= move_start ? gap : cnt_reg - {7'h00, cnt_reg != 8'h00};
      end
endmodule // prs_table_model
`default_nettype wire

// ### dv/point_table_repeat_sequencer_bench.sv
// Bench for the point table repeat sequencer.
// Assumes the table model as far side; inputs change at falling edges.
`timescale 1ns/10ps
`default_nettype none
module point_table_repeat_sequencer_bench;
   typedef struct packed {logic [7:0] st; logic mth; logic [31:0] subs; logic [23:0] seq;
      logic [7:0] gap;} prs_row_s;
   prs_row_s rows [5] = '{
      '{8'h02, 1'b0, 32'h0008_3110, 24'h432432, 8'h01},
      '{8'h02, 1'b0, 32'h0000_9110, 24'h132132, 8'h09},
      '{8'h02, 1'b0, 32'h000a_1310, 24'h432432, 8'h03},
      '{8'h02, 1'b1, 32'h0000_b130, 24'h132132, 8'h01},
      '{8'h01, 1'b1, 32'h0000_0810, 24'h212121, 8'h01}};
   logic ref_clk = 1'b0, reset = 1'b1, start_req = 1'b0, stop_req = 1'b0, mth = 1'b0;
   logic [7:0] start_entry = 8'h00, gap = 8'h01, entry_addr, got;
   logic [31:0] pos;
   logic [31:0] mv_pos;
   logic [15:0] mv_spd, mv_acc, mv_dec, mv_dwl;
   logic [7:0] cur;
   logic [3:0] sub;
   logic entry_rd, move_start, move_done, busy;
   int num_errors = 0, checks = 0, cyc = 0;
   prs_sequencer dut (.ref_clk(ref_clk), .reset(reset), .start_req(start_req),
      .stop_req(stop_req), .start_entry(start_entry), .command_method_select(mth),
      .entry_rd(entry_rd), .entry_addr(entry_addr), .entry_data_pos(pos),
      .entry_data_speed(pos[15:0]), .entry_data_accel(~pos[15:0]),
      .entry_data_decel(pos[31:16]), .entry_data_dwell({pos[7:0], pos[31:24]}),
      .entry_data_sub(sub), .move_start(move_start),
      .move_pos(mv_pos), .move_speed(mv_spd), .move_accel(mv_acc), .move_decel(mv_dec),
      .move_dwell(mv_dwl), .move_incremental(), .move_done(move_done), .busy(busy),
      .current_entry(cur));
   prs_table_model prt (.ref_clk(ref_clk), .reset(reset), .entry_addr(entry_addr),
      .move_start(move_start), .gap(gap), .pos(pos), .sub(sub), .move_done(move_done));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic fetch(output logic [7:0] a);
      a = 8'hxx;
      for (int n = 0; n < 40; n++)
      begin
         if (entry_rd === 1'b1)
         begin
            a = entry_addr;
            break;
         end
         @(negedge ref_clk);
      end
      repeat (2) @(negedge ref_clk);
      chk("move_start", 32'h1, {31'h0, move_start});
      chk("move_pos", {8'ha5, 16'h0000, a}, mv_pos);
      chk("move_speed", {24'h0, a}, {16'h0, mv_spd});
      chk("move_accel", {16'h0, 8'hff, ~a}, {16'h0, mv_acc});
      chk("move_decel", 32'ha500, {16'h0, mv_dec});
      chk("move_dwell", {16'h0, a, 8'ha5}, {16'h0, mv_dwl});
      chk("current_entry", {24'h0, a}, {24'h0, cur});
   endtask
   task automatic go(input logic [7:0] s);
      @(negedge ref_clk);
      start_entry = s;
      start_req = 1'b1;
      @(negedge ref_clk);
      start_req = 1'b0;
   endtask
   task automatic halt();
      @(negedge ref_clk);
      stop_req = 1'b1;
      @(negedge ref_clk);
      stop_req = 1'b0;
      repeat (16) @(negedge ref_clk);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial forever #10 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         num_errors++;
         give_verdict();
      end
   end
   //****************************************
   // Main sequence
   //****************************************
   initial
   begin
      repeat (16) @(negedge ref_clk);
      chk("busy in reset", 32'h0, {31'h0, busy});
      reset = 1'b0;
      foreach (rows[r])
      begin
         for (int i = 0; i < 8; i++) prt.sub_mem[i] = rows[r].subs[4*i +: 4];
         mth = rows[r].mth;
         gap = rows[r].gap;
         go(rows[r].st);
         for (int k = 0; k < 6; k++)
         begin
            fetch(got);
            chk("entry_addr", {28'h0, rows[r].seq[4*k +: 4]}, {24'h0, got});
         end
         halt();
         $display("row %0d done", r);
      end
      prt.sub_mem[6] = 4'h1;
      prt.sub_mem[7] = 4'h2;
      mth = 1'b0;
      go(8'h06);
      fetch(got);
      fetch(got);
      chk("last entry", 32'h7, {24'h0, got});
      repeat (20) @(negedge ref_clk);
      chk("busy after end", 32'h0, {31'h0, busy});
      $display("chain end done");
      go(8'h01);
      fetch(got);
      go(8'h05);
      fetch(got);
      chk("start while busy", 32'h2, {24'h0, got});
      halt();
      $display("refused start done");
      go(8'h01);
      fetch(got);
      reset = 1'b1;
      @(negedge ref_clk);
      chk("busy mid reset", 32'h0, {31'h0, busy});
      reset = 1'b0;
      repeat (16) @(negedge ref_clk);
      go(8'h02);
      fetch(got);
      chk("start after reset", 32'h2, {24'h0, got});
      halt();
      $display("mid reset done");
      give_verdict();
   end
endmodule // point_table_repeat_sequencer_bench
`default_nettype wire
